/* File: hw/fsl_pkg.sv */
// fault snapshot logger package: constants, record layout and types
// assumes a 250 MHz system clock and a controller-driven link clock
// Contract
// RULE_01 - fault recording happens only when the memory is configured for fault log mode
// RULE_02 - configuration picks scratch storage or fault log storage, never both
// RULE_03 - each record is seven bytes: six status bytes plus one user byte
// RULE_04 - byte 0 user bits; bytes 1-6 status; last byte low bits 1,0,1
// RULE_05 - erased or never written slots read back as all zeros
// RULE_06 - records go to the nonvolatile array or the volatile register
// RULE_07 - the nonvolatile array holds up to 16 records filled in order
// RULE_08 - when the array is full, later triggers are ignored
// RULE_09 - volatile mode keeps one record, overwritten on every trigger
// RULE_10 - controller reads the volatile record before the next trigger to keep it
// RULE_11 - controller holds the trigger high for at least the minimum period
// RULE_12 - one trigger starts recording in every expander at once
// RULE_13 - a trigger while read-back is enabled stores nothing
// RULE_14 - the link reports that the nonvolatile array is full
// RULE_15 - the link reports that a log write is in progress
// RULE_16 - in fault log mode a fresh status frame is captured every 16 us
// RULE_17 - a trigger writes the latest captured frame with the user bits
// RULE_18 - user bits serve fault records only
// RULE_19 - reads and erases are accepted only while read-back is enabled
// RULE_20 - enabling read-back stops recording until the host re-enables it
// RULE_21 - the host may read and erase both the array and the volatile register
// RULE_22 - full stays set until erase; an ignored trigger raises no in-progress

package fsl_pkg;

	// ****************************************************************
	// sizes and timing
	// ****************************************************************
	localparam int REC_BYTES = 7;
	localparam int REC_BITS = 56;
	localparam int NV_DEPTH = 16;
	localparam int IDX_W = 4;
	localparam int SYS_CLK_MHZ = 250;
	localparam int SNAP_PERIOD_US = 16;
	localparam int SNAP_CYCLES = SNAP_PERIOD_US * SYS_CLK_MHZ;
	localparam int SNAP_CNT_W = 12;
	localparam int NV_WRITE_CYCLES = 8;
	localparam logic [2:0] TAIL_BITS = 3'h5;
	localparam logic [7:0] USER_BYTE_RST = 8'h00;

	// ****************************************************************
	// record content and host request types
	// ****************************************************************
	typedef struct packed {
		logic analog_good_flag;
		logic [9:0] gpio;
		logic [3:0] high_side_driver_output;
		logic [1:0] current_monitor;
		logic [1:0] high_voltage_current_monitor;
		logic [1:0] high_voltage_monitor;
		logic [17:0] voltage_monitor;
		logic [3:0] temperature_monitor;
		logic [1:0] internal_temperature_monitor;
	} fsl_status_t;

	typedef struct packed {
		logic rd;
		logic erase;
		logic sel_volatile;
		logic [3:0] idx;
	} fsl_host_req_t;

endpackage : fsl_pkg

/* File: hw/fsl_logger.sv */
// fault snapshot logger: samples the status frame, stores it on trigger
// assumes trigger and user bits arrive on the link clock; host side on sys_clk
`timescale 1ns/1ps

module fsl_logger
	import fsl_pkg::*;
(
	input wire logic sys_clk, // system clock, 250 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic link_clk, // expander link clock from controller
	input wire logic link_trigger, // fault log trigger, link domain
	input wire logic [7:0] link_user_bits, // user byte, link domain
	output logic log_array_full, // array full indication, link domain
	output logic log_write_active, // write in progress, link domain
	input wire fsl_status_t status_in, // live monitor and pin states
	input wire logic cfg_fault_log_mode, // 1 fault log, 0 scratch storage
	input wire logic cfg_volatile, // 1 store to volatile register
	input wire logic readback_en, // host read-back enable
	input wire fsl_host_req_t host_req, // host read or erase request
	output logic host_ack, // request taken, high one cycle after each cycle a request is accepted
	output logic [REC_BITS-1:0] host_rdata, // record read back
	output logic [IDX_W:0] rec_count // records held in array
);

	// ****************************************************************
	// link domain: capture trigger and user bits
	// ****************************************************************
	logic [7:0] user_l_ff;
	logic trig_l_ff;
	logic trig_tgl_ff;
	logic [1:0] full_l_ff;
	logic [1:0] busy_l_ff;
	logic full_s;
	logic busy_s;
	wire trig_rise_l = link_trigger & ~trig_l_ff;

	// user byte goes nowhere but the record
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			user_l_ff <= USER_BYTE_RST;
			trig_l_ff <= 1'b0;
			trig_tgl_ff <= 1'b0;
		end else begin
			user_l_ff <= link_user_bits; // RULE_18
			trig_l_ff <= link_trigger; // RULE_11
			trig_tgl_ff <= trig_tgl_ff ^ trig_rise_l; // RULE_12
		end
	end

	// status flags back onto the link clock, two flops
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			full_l_ff <= 2'h0;
			busy_l_ff <= 2'h0;
		end else begin
			full_l_ff <= {full_l_ff[0], full_s};
			busy_l_ff <= {busy_l_ff[0], busy_s};
		end
	end
	assign log_array_full = full_l_ff[1]; // RULE_14
	assign log_write_active = busy_l_ff[1]; // RULE_15

	// ****************************************************************
	// crossing into sys_clk: toggle and user byte, three flops
	// ****************************************************************
	logic [2:0] tgl_sync_ff;
	logic tgl_seen_ff;
	logic [7:0] user_s1_ff;
	logic [7:0] user_s2_ff;
	logic [7:0] user_s3_ff;
	wire trig_evt = (tgl_sync_ff[1] == tgl_sync_ff[2])
		& (tgl_sync_ff[2] != tgl_seen_ff);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tgl_sync_ff <= 3'h0;
			tgl_seen_ff <= 1'b0;
			user_s1_ff <= USER_BYTE_RST;
			user_s2_ff <= USER_BYTE_RST;
			user_s3_ff <= USER_BYTE_RST;
		end else begin
			tgl_sync_ff <= {tgl_sync_ff[1:0], trig_tgl_ff};
			if (trig_evt) begin
				tgl_seen_ff <= tgl_sync_ff[2];
			end
			user_s1_ff <= user_l_ff;
			user_s2_ff <= user_s1_ff;
			if (user_s2_ff == user_s3_ff || trig_evt == 1'b0) begin
				user_s3_ff <= user_s2_ff;
			end
		end
	end

	// ****************************************************************
	// periodic frame capture
	// ****************************************************************
	logic [SNAP_CNT_W-1:0] snap_cnt_ff;
	logic [REC_BITS-1:0] frame_ff;
	wire snap_tick = (snap_cnt_ff == SNAP_CNT_W'(SNAP_CYCLES - 1));
	// gpio[6] has no place in the record; the spare bit reads as 0
	wire [REC_BITS-1:0] live_frame = {user_s3_ff, status_in.analog_good_flag,
		status_in.gpio[9:7], 1'b0, status_in.gpio[5:0],
		status_in.high_side_driver_output, status_in.current_monitor,
		status_in.high_voltage_current_monitor,
		status_in.high_voltage_monitor, status_in.voltage_monitor,
		status_in.temperature_monitor,
		status_in.internal_temperature_monitor, TAIL_BITS}; // RULE_03 RULE_04

	// frame refreshed every 16 us while in fault log mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			snap_cnt_ff <= '0;
			frame_ff <= '0;
		end else if (cfg_fault_log_mode) begin
			snap_cnt_ff <= snap_tick ? '0 : snap_cnt_ff + 1'b1; // RULE_16
			if (snap_tick) begin
				frame_ff <= live_frame; // RULE_16
			end
		end else begin
			snap_cnt_ff <= '0;
		end
	end

	// ****************************************************************
	// recording control
	// ****************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_NV_WR, ST_VOL_WR} fsl_state_t;
	fsl_state_t state_ff;
	fsl_state_t nxt_state;
	logic [2:0] wr_cnt_ff;
	logic rec_en_ff;
	logic [IDX_W:0] cnt_ff;
	logic [REC_BITS-1:0] mem_ff [NV_DEPTH];
	logic [REC_BITS-1:0] vol_ff;
	logic [REC_BITS-1:0] wr_data_ff;
	logic [REC_BITS-1:0] rdata_ff;
	logic ack_ff;
	logic full_ff;

	wire array_full = (cnt_ff == (IDX_W+1)'(NV_DEPTH)); // RULE_07
	// a trigger during a write is dropped, so a write never restarts
	wire rec_ok = cfg_fault_log_mode & rec_en_ff & ~readback_en
		& (state_ff == ST_IDLE); // RULE_01 RULE_13 RULE_22
	wire start_nv = trig_evt & rec_ok & ~cfg_volatile & ~array_full; // RULE_08
	wire start_vol = trig_evt & rec_ok & cfg_volatile; // RULE_09
	wire wr_done = (wr_cnt_ff == 3'(NV_WRITE_CYCLES - 1));
	wire host_ok = readback_en & cfg_fault_log_mode; // RULE_19 RULE_02
	wire do_rd = host_ok & host_req.rd; // RULE_21
	wire do_erase = host_ok & host_req.erase & ~host_req.rd; // RULE_21

	// next-state selection
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_nv) begin
					nxt_state = ST_NV_WR;
				end else if (start_vol) begin
					nxt_state = ST_VOL_WR;
				end
			end
			ST_NV_WR: begin
				if (wr_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_VOL_WR: begin
				// held as long as an array write so the link sees it
				if (wr_done) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	assign busy_s = (state_ff != ST_IDLE); // RULE_15 RULE_22
	// registered so no decode glitch reaches the link domain
	assign full_s = full_ff; // RULE_14 RULE_22

	// state, write timer and the recording enable
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			wr_cnt_ff <= 3'h0;
			rec_en_ff <= 1'b1;
			wr_data_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			wr_cnt_ff <= (state_ff != ST_IDLE) ? wr_cnt_ff + 3'h1 : 3'h0;
			if (start_nv | start_vol) begin
				wr_data_ff <= frame_ff; // RULE_17
			end
			if (readback_en) begin
				rec_en_ff <= 1'b0; // RULE_20
			end else if (host_req.rd == 1'b0 && host_req.erase == 1'b0
				&& rec_en_ff == 1'b0) begin
				rec_en_ff <= 1'b1; // RULE_20
			end
		end
	end

	// ****************************************************************
	// storage: array slots, count and volatile register
	// ****************************************************************
	for (genvar gi = 0; gi < NV_DEPTH; gi++) begin : g_slot
		wire slot_wr = (state_ff == ST_NV_WR) & wr_done
			& (cnt_ff[IDX_W-1:0] == IDX_W'(gi)); // RULE_07
		wire slot_clr = do_erase & ~host_req.sel_volatile; // RULE_05
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				mem_ff[gi] <= '0;
			end else if (slot_wr) begin
				mem_ff[gi] <= wr_data_ff; // RULE_06
			end else if (slot_clr) begin
				mem_ff[gi] <= '0;
			end
		end
	end

	// fill count, volatile record, host answers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
			vol_ff <= '0;
			rdata_ff <= '0;
			ack_ff <= 1'b0;
			full_ff <= 1'b0;
		end else begin
			full_ff <= array_full; // RULE_14
			if ((state_ff == ST_NV_WR) && wr_done) begin
				cnt_ff <= cnt_ff + 1'b1; // RULE_07
			end else if (do_erase && !host_req.sel_volatile) begin
				cnt_ff <= '0; // RULE_22
			end
			if (state_ff == ST_VOL_WR && wr_done) begin
				vol_ff <= wr_data_ff; // RULE_09
			end else if (do_erase && host_req.sel_volatile) begin
				vol_ff <= '0; // RULE_05
			end
			if (do_rd) begin
				rdata_ff <= host_req.sel_volatile ? vol_ff
					: mem_ff[host_req.idx]; // RULE_21
			end
			ack_ff <= do_rd | do_erase;
		end
	end

	assign host_ack = ack_ff;
	assign host_rdata = rdata_ff;
	assign rec_count = cnt_ff;

	// ****************************************************************
	// checks
	// ****************************************************************
	AST_FULL_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
		array_full && !cfg_volatile |-> !start_nv) // RULE_08
		else $error("trigger accepted while array full");

	AST_RB_BLOCKS: assert property (@(posedge sys_clk) disable iff (rst)
		readback_en |=> !start_nv && !start_vol) // RULE_13
		else $error("recording started during read-back");

	AST_VOL_STORE: assert property (@(posedge sys_clk) disable iff (rst)
		start_vol |-> ##9 vol_ff == $past(frame_ff, 9)) // RULE_09
		else $error("volatile record not overwritten");

	AST_NV_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
		start_nv |=> busy_s [*8] ##1 !busy_s) // RULE_15
		else $error("write busy length wrong");

	AST_VOL_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
		start_vol |=> busy_s [*8] ##1 !busy_s) // RULE_15
		else $error("volatile busy length wrong");

	AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (rst)
		start_nv |-> ##9 cnt_ff == $past(cnt_ff, 9) + 1'b1) // RULE_07
		else $error("record count did not advance");

	AST_TAIL: assert property (@(posedge sys_clk) disable iff (rst)
		frame_ff[2:0] == TAIL_BITS || frame_ff == '0) // RULE_04
		else $error("record tail bits wrong");

	AST_NO_HOST: assert property (@(posedge sys_clk) disable iff (rst)
		!readback_en |=> !host_ack) // RULE_19
		else $error("host access without read-back");

	AST_ERASE_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		do_erase && host_req.sel_volatile && state_ff == ST_IDLE
		|=> vol_ff == '0) // RULE_05
		else $error("erase left data");

	AST_MODE_ONLY: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_fault_log_mode |-> !start_nv && !start_vol) // RULE_01
		else $error("recording outside fault log mode");

	// ****************************************************************
	// checks: capture, host answers and recording enable
	// ****************************************************************
	AST_IDLE_START: assert property (@(posedge sys_clk) disable iff (rst)
		start_nv || start_vol |-> state_ff == ST_IDLE) // RULE_22
		else $error("write started while busy");

	AST_WR_CAPTURE: assert property (@(posedge sys_clk) disable iff (rst)
		start_nv || start_vol |=> wr_data_ff == $past(frame_ff)) // RULE_17
		else $error("latest frame not taken for the write");

	AST_SNAP_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!snap_tick |=> $stable(frame_ff)) // RULE_16
		else $error("frame changed between snapshots");

	AST_USER_BYTE: assert property (@(posedge sys_clk) disable iff (rst)
		snap_tick && cfg_fault_log_mode
		|=> frame_ff[55:48] == $past(user_s3_ff)) // RULE_03 RULE_18
		else $error("user byte not in record byte 0");

	AST_FULL_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
		array_full && !(do_erase && !host_req.sel_volatile)
		|=> array_full) // RULE_22
		else $error("full dropped without erase");

	AST_REC_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		readback_en |=> !rec_en_ff) // RULE_20
		else $error("recording left enabled during read-back");

	AST_ACK: assert property (@(posedge sys_clk) disable iff (rst)
		do_rd || do_erase |=> host_ack) // RULE_21
		else $error("host request not acknowledged");

	AST_VOL_READ: assert property (@(posedge sys_clk) disable iff (rst)
		do_rd && host_req.sel_volatile
		|=> host_rdata == $past(vol_ff)) // RULE_21
		else $error("volatile read data wrong");

	AST_SCRATCH_HOST: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg_fault_log_mode |=> !host_ack) // RULE_02
		else $error("fault log access in scratch mode");

endmodule : fsl_logger

/* File: tb/fsl_ctrl_model.sv */
// controller model: makes the link clock, drives trigger and user byte
// assumes the logger samples trigger and user bits on link_clk
`timescale 1ns/1ps

module fsl_ctrl_model (
	output logic link_clk, // link clock, 30 ns period
	output logic link_trigger, // fault log trigger
	output logic [7:0] link_user_bits, // user byte to the record
	input wire logic log_write_active, // write in progress from logger
	output int writes_seen // starts of log writes seen
);
	// ****************************************************************
	// link side
	// ****************************************************************
	logic active_ff = 1'b0;

	// free running link clock and idle levels
	initial begin
		link_clk = 1'b0;
		link_trigger = 1'b0;
		link_user_bits = 8'ha7;
		writes_seen = 0;
	end
	always #15 link_clk = ~link_clk;

	// count each start of a log write seen on the link
	always @(posedge link_clk) begin
		active_ff <= log_write_active;
		if (log_write_active === 1'b1 && active_ff === 1'b0) begin
			writes_seen <= writes_seen + 1;
		end
	end

	// user byte is a level, held until changed
	task automatic set_user(input logic [7:0] ub);
		@(posedge link_clk);
		link_user_bits <= ub;
	endtask : set_user

	// one trigger: high for 3 link clocks, then spacing before the next
	task automatic fire();
		@(posedge link_clk);
		link_trigger <= 1'b1;
		repeat (3) @(posedge link_clk);
		link_trigger <= 1'b0;
		repeat (16) @(posedge link_clk);
	endtask : fire
endmodule : fsl_ctrl_model

/* File: tb/tb_top.sv */
// testbench: fills, reads and erases the fault log through its ports
// assumes fsl_pkg and the controller model are compiled first
`timescale 1ns/1ps

module tb_top
	import fsl_pkg::*;
;
	// ****************************************************************
	// stimulus and checks
	// ****************************************************************
	localparam logic [44:0] STAT = 45'h1234_5678_9abc;
	logic sys_clk = 1'b0;
	logic rst, link_clk, link_trigger, log_array_full, log_write_active;
	logic cfg_fault_log_mode, cfg_volatile, readback_en, host_ack;
	logic [7:0] link_user_bits;
	fsl_status_t status_in;
	fsl_host_req_t host_req;
	logic [REC_BITS-1:0] host_rdata, rdata;
	logic [IDX_W:0] rec_count;
	int writes_seen;
	int errors = 0;
	int checks = 0;
	int cyc = 0;

	fsl_logger u_fsl_logger (.sys_clk(sys_clk), .rst(rst),
		.link_clk(link_clk), .link_trigger(link_trigger),
		.link_user_bits(link_user_bits), .log_array_full(log_array_full),
		.log_write_active(log_write_active), .status_in(status_in),
		.cfg_fault_log_mode(cfg_fault_log_mode), .cfg_volatile(cfg_volatile),
		.readback_en(readback_en), .host_req(host_req), .host_ack(host_ack),
		.host_rdata(host_rdata), .rec_count(rec_count));

	fsl_ctrl_model u_fsl_ctrl_model (.link_clk(link_clk),
		.link_trigger(link_trigger), .link_user_bits(link_user_bits),
		.log_write_active(log_write_active), .writes_seen(writes_seen));

	// system clock and watchdog
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			wrap_up();
		end
	end

	// expected record: user byte, status less gpio[6], spare 0, tail 101
	function automatic logic [55:0] rec(input logic [7:0] ub);
		return {ub, STAT[44:41], 1'b0, STAT[39:0], 3'h5};
	endfunction : rec

	task automatic chk(input string what, input logic [63:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// hold a host request until acknowledged, take data, then release
	task automatic host(input logic rd, er, vol, input logic [3:0] idx);
		int n;
		n = 0;
		@(posedge sys_clk);
		host_req <= '{rd, er, vol, idx};
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (host_ack !== 1'b1 && n < 8);
		rdata = host_rdata;
		chk("host_ack", host_ack, 1'b1);
		@(posedge sys_clk);
		host_req <= '0;
	endtask : host

	// let the next 16 us snapshot land
	task automatic snap();
		repeat (SNAP_CYCLES + 100) @(posedge sys_clk);
	endtask : snap

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// main sequence
	initial begin
		rst = 1'b1;
		status_in = fsl_status_t'(STAT);
		cfg_fault_log_mode = 1'b0;
		cfg_volatile = 1'b0;
		readback_en = 1'b0;
		host_req = '0;
		repeat (3) @(posedge sys_clk);
		repeat (2) @(posedge link_clk);
		@(posedge sys_clk);
		rst <= 1'b0;
		u_fsl_ctrl_model.fire();
		chk("scratch count", rec_count, 0);
		chk("scratch writes", writes_seen, 0);
		@(posedge sys_clk);
		cfg_fault_log_mode <= 1'b1;
		host_req <= '{1'b1, 1'b0, 1'b0, 4'h0};
		repeat (4) begin
			@(posedge sys_clk);
			#1 chk("no ack", host_ack, 0);
		end
		readback_en <= 1'b1;
		host(1'b1, 1'b0, 1'b0, 4'h0);
		chk("blank slot", rdata, 0);
		readback_en <= 1'b0;
		snap();
		for (int i = 0; i < NV_DEPTH; i++) begin
			chk("full early", log_array_full, 0);
			u_fsl_ctrl_model.fire();
			chk("count", rec_count, i + 1);
		end
		chk("full", log_array_full, 1);
		u_fsl_ctrl_model.fire();
		chk("count held", rec_count, NV_DEPTH);
		chk("no write", writes_seen, NV_DEPTH);
		chk("full held", log_array_full, 1);
		readback_en <= 1'b1;
		host(1'b1, 1'b0, 1'b0, 4'h0);
		chk("slot 0", rdata, rec(8'ha7));
		host(1'b1, 1'b0, 1'b0, 4'hf);
		chk("slot 15", rdata, rec(8'ha7));
		host(1'b0, 1'b1, 1'b0, 4'h0);
		repeat (4) @(posedge link_clk);
		chk("erased count", rec_count, 0);
		chk("full cleared", log_array_full, 0);
		host(1'b1, 1'b0, 1'b0, 4'h3);
		chk("erased slot", rdata, 0);
		readback_en <= 1'b0;
		cfg_volatile <= 1'b1;
		repeat (8) @(posedge sys_clk);
		u_fsl_ctrl_model.fire();
		readback_en <= 1'b1;
		host(1'b1, 1'b0, 1'b1, 4'h0);
		chk("volatile a", rdata, rec(8'ha7));
		chk("array idle", rec_count, 0);
		readback_en <= 1'b0;
		u_fsl_ctrl_model.set_user(8'h3c);
		snap();
		u_fsl_ctrl_model.fire();
		readback_en <= 1'b1;
		host(1'b1, 1'b0, 1'b1, 4'h0);
		chk("volatile b", rdata, rec(8'h3c));
		u_fsl_ctrl_model.set_user(8'h5e);
		snap();
		u_fsl_ctrl_model.fire();
		chk("blocked writes", writes_seen, NV_DEPTH + 2);
		host(1'b1, 1'b0, 1'b1, 4'h0);
		chk("volatile kept", rdata, rec(8'h3c));
		host(1'b0, 1'b1, 1'b1, 4'h0);
		host(1'b1, 1'b0, 1'b1, 4'h0);
		chk("volatile erased", rdata, 0);
		readback_en <= 1'b0;
		repeat (8) @(posedge sys_clk);
		u_fsl_ctrl_model.fire();
		chk("re-enabled", writes_seen, NV_DEPTH + 3);
		readback_en <= 1'b1;
		host(1'b1, 1'b0, 1'b1, 4'h0);
		chk("volatile c", rdata, rec(8'h5e));
		wrap_up();
	end
endmodule : tb_top
